/* File: verilog/lcd_seq_pkg.sv */
// constants, types and register map of the segment display frame sequencer
// assumes a single 250 MHz system clock domain
package lcd_seq_pkg;
    localparam int NUM_COMS       = 4;
    localparam int NUM_SEGS       = 24;
    localparam int ADDR_W         = 4;
    localparam int DATA_W         = 8;
    localparam int PIX_WORDS      = 12;
    localparam int WORDS_PER_COM  = 3;
    // register indices
    localparam logic [3:0] ADDR_PIX_LAST = 4'hB;
    localparam logic [3:0] ADDR_CTRL     = 4'hC;
    localparam logic [3:0] ADDR_CFG      = 4'hD;
    localparam logic [3:0] ADDR_STAT     = 4'hE;
    // control register fields
    localparam int CTRL_EN_BIT    = 7;
    localparam int CTRL_SLP_BIT   = 6;
    localparam int CTRL_WRITE_ERROR_FLAG_BIT  = 5;
    localparam int CTRL_CS_LSB    = 2;
    localparam int CTRL_MUX_LSB   = 0;
    // config register fields
    localparam int CFG_WFT_BIT    = 7;
    localparam int CFG_IE_BIT     = 0;
    // status register fields
    localparam int STAT_ACT_BIT   = 2;
    localparam int STAT_IF_BIT    = 0;
    localparam logic [1:0] CS_FOSC4   = 2'h0;
    localparam logic [1:0] CS_SECOSC  = 2'h1;
    localparam logic [1:0] CS_LFOSC   = 2'h2;
    localparam logic [1:0] CS_FOSC256 = 2'h3;
    localparam logic [1:0] MUX_STATIC = 2'h0;
    // last tick count of the module clock in a phase half, counted from zero; a slot is two halves
    localparam logic [7:0] TICKS_PER_HALF = 8'h0F;
    // tick count in the second half of the last slot when fetch completes, and write window length
    localparam logic [7:0] FETCH_DONE_TICK = 8'h0C;
    localparam logic [7:0] WRITE_WIN_TICKS = 8'h08;
    localparam logic [7:0] DIV256_LAST     = 8'hFF;
    localparam logic [1:0] DIV4_LAST       = 2'h3;
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_DRAIN = 2'b11,
        ST_HALT  = 2'b10
    } seq_state_t;
endpackage

/* File: verilog/lcd_pix_mem.sv */
// twelve-byte pixel store with registered read port
// assumes writes are already qualified by the sequencer
module lcd_pix_mem
    import lcd_seq_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem_r [PIX_WORDS];

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < PIX_WORDS; i++)
                mem_r[i] <= '0;
        end
        else if (wr_en)
            mem_r[wr_addr] <= wr_data;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_data <= '0;
        else if (rd_addr <= ADDR_PIX_LAST)
            rd_data <= mem_r[rd_addr];
        else
            rd_data <= '0;
    end
endmodule

/* File: verilog/lcd_frame_seq.sv */
// frame sequencing, frame and shutdown interrupt, sleep behaviour of a segment driver
// assumes external clock ticks are already on sys_clk as raw levels; pins after the pad mux
// Operation
// - drive com and seg so each pixel has zero dc; dark pixel gets higher rms
// - type a inverts within each slot; type b inverts each frame boundary
// - display interrupt raised when the active flag falls from one to zero
// - a frame starts at the leading edge of the first common line drive
// - frame interrupt set when pixel fetch for a frame completes, fixed lead before boundary
// - type b frame interrupts only at completed phase intervals, whole frame pairs
// - pixel write while writes are disabled is dropped and sets the write error flag
// - no frame interrupt with type a, nor with type b in static drive
// - sleep with shutdown enable set stops at once, all lines to ground
// - clearing enable finishes the frame, clears active flag, may interrupt, pins released
// - sleep, shutdown enable clear, quarter-rate clock: halt holding last pattern
// - divide-by-256 clock: sleep halts the module immediately regardless of shutdown enable
// - shutdown enable clear on slow oscillators: keep refreshing, block data writes
// - asleep with frame interrupts active and enabled: wake at next frame boundary
// - mux select 00 one common, 01 two, 10 three, 11 four
//
// The address map and the strobed register port were left to the implementer.
module lcd_frame_seq
    import lcd_seq_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    input  wire logic                sleep_req,
    input  wire logic                sec_osc_clk,
    input  wire logic                lf_osc_clk,
    output logic                     display_irq,
    output logic                     wake_req,
    output logic      [NUM_COMS-1:0] com_drive,
    output logic      [NUM_COMS-1:0] com_phase,
    output logic      [NUM_SEGS-1:0] seg_drive,
    output logic                     pins_lcd_mode
);
    logic [DATA_W-1:0]   ctrl_r;
    logic                wft_r;
    logic                ie_r;
    logic                display_irq_flag_r;
    logic                display_active_flag_r;
    logic                rd_pend_r;
    logic [DATA_W-1:0]   rd_hold_r;
    logic                sec_m_r, sec_s_r, sec_d_r;
    logic                lf_m_r, lf_s_r, lf_d_r;
    logic                slp_m_r, slp_s_r;
    logic [7:0]          div256_r;
    logic [1:0]          div4_r;
    logic [7:0]          tick_cnt_r;
    logic [1:0]          slot_r;
    logic                half_r;
    logic                frame_par_r;
    logic [7:0]          win_cnt_r;
    logic [DATA_W-1:0]   fetch_r [WORDS_PER_COM];
    logic [1:0]          fetch_idx_r;
    logic [ADDR_W-1:0]   mem_raddr;
    logic [DATA_W-1:0]   mem_rdata;
    logic                active_d_r;
    seq_state_t          state_r, state_nxt;

    wire logic       display_enable        = ctrl_r[CTRL_EN_BIT];
    wire logic       sleep_shutdown_enable = ctrl_r[CTRL_SLP_BIT];
    wire logic [1:0] clk_sel               = ctrl_r[CTRL_CS_LSB +: 2];
    wire logic [1:0] multiplex_select      = ctrl_r[CTRL_MUX_LSB +: 2];
    wire logic       asleep                = slp_s_r;
    wire logic       is_pix                = reg_addr <= ADDR_PIX_LAST;
    wire logic       frame_irq_on          = wft_r && (multiplex_select != MUX_STATIC);
    wire logic       slow_osc              = (clk_sel == CS_SECOSC) || (clk_sel == CS_LFOSC);
    wire logic       freeze_sleep          = asleep && (sleep_shutdown_enable ||
                                             (clk_sel == CS_FOSC4) || (clk_sel == CS_FOSC256));
    wire logic       last_slot             = (slot_r >= multiplex_select);
    wire logic       slot_end;
    wire logic       tick;
    wire logic       frame_start;
    wire logic       fetch_done;
    wire logic       write_ok;
    wire logic       pix_wr;

    // external clocks and sleep request pass two flops
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sec_m_r <= 1'b0; sec_s_r <= 1'b0; sec_d_r <= 1'b0;
            lf_m_r  <= 1'b0; lf_s_r  <= 1'b0; lf_d_r  <= 1'b0;
            slp_m_r <= 1'b0; slp_s_r <= 1'b0;
        end
        else
        begin
            sec_m_r <= sec_osc_clk; sec_s_r <= sec_m_r; sec_d_r <= sec_s_r;
            lf_m_r  <= lf_osc_clk;  lf_s_r  <= lf_m_r;  lf_d_r  <= lf_s_r;
            slp_m_r <= sleep_req;   slp_s_r <= slp_m_r;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div256_r <= '0;
            div4_r   <= '0;
        end
        else
        begin
            div256_r <= div256_r + 8'h01;
            div4_r   <= div4_r + 2'h1;
        end
    end

    logic tick_sel;
    always_comb
    begin
        case (clk_sel)
            CS_FOSC4:   tick_sel = (div4_r == DIV4_LAST);
            CS_SECOSC:  tick_sel = sec_s_r && !sec_d_r;
            CS_LFOSC:   tick_sel = lf_s_r && !lf_d_r;
            default:    tick_sel = (div256_r == DIV256_LAST);
        endcase
    end
    assign tick = tick_sel && !freeze_sleep;

    assign slot_end    = tick && half_r && (tick_cnt_r == TICKS_PER_HALF);
    assign frame_start = slot_end && last_slot;
    assign fetch_done  = tick && half_r && last_slot && (tick_cnt_r == FETCH_DONE_TICK);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:  if (display_enable) state_nxt = ST_RUN;
            ST_RUN:   if (!display_enable) state_nxt = ST_DRAIN;
            ST_DRAIN: if (frame_start && !display_enable) state_nxt = ST_IDLE;
            ST_HALT:  state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            display_active_flag_r <= 1'b0;
        else
            display_active_flag_r <= (state_nxt == ST_RUN) || (state_nxt == ST_DRAIN);
    end

    // slot timing: two phase halves per common slot
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tick_cnt_r  <= '0;
            half_r      <= 1'b0;
            slot_r      <= '0;
            frame_par_r <= 1'b0;
        end
        else if (!display_active_flag_r)
        begin
            tick_cnt_r  <= '0;
            half_r      <= 1'b0;
            slot_r      <= '0;
            frame_par_r <= 1'b0;
        end
        else if (tick)
        begin
            if (tick_cnt_r == TICKS_PER_HALF)
            begin
                tick_cnt_r <= '0;
                half_r     <= !half_r;
                if (half_r)
                begin
                    slot_r <= last_slot ? 2'h0 : slot_r + 2'h1;
                    if (last_slot)
                        frame_par_r <= !frame_par_r;
                end
            end
            else
                tick_cnt_r <= tick_cnt_r + 8'h01;
        end
    end

    // write window opens at fetch completion
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            win_cnt_r <= '0;
        else if (fetch_done && (!frame_irq_on || frame_par_r))
            win_cnt_r <= WRITE_WIN_TICKS;
        else if (tick && win_cnt_r != 8'h00)
            win_cnt_r <= win_cnt_r - 8'h01;
    end

    // type b multiplexed while active: writes only inside the window; any mode: none while asleep
    assign write_ok = !asleep && (!frame_irq_on || !display_active_flag_r || win_cnt_r != 8'h00);
    assign pix_wr   = reg_wr && is_pix && write_ok;

    // slot fetch from the pixel store
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            fetch_idx_r <= '0;
        else
            fetch_idx_r <= (fetch_idx_r == 2'(WORDS_PER_COM - 1)) ? 2'h0 : fetch_idx_r + 2'h1;
    end
    always_comb
    begin
        mem_raddr = reg_rd ? reg_addr : ADDR_W'(slot_r * WORDS_PER_COM + fetch_idx_r);
    end

    lcd_pix_mem u_mem
    (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .wr_en   (pix_wr),
        .wr_addr (reg_addr),
        .wr_data (reg_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    logic [1:0] fetch_idx_d_r;
    logic       rd_d_r;
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fetch_idx_d_r <= '0;
            rd_d_r        <= 1'b0;
            for (int i = 0; i < WORDS_PER_COM; i++)
                fetch_r[i] <= '0;
        end
        else
        begin
            fetch_idx_d_r <= fetch_idx_r;
            rd_d_r        <= reg_rd;
            if (!rd_d_r && !freeze_sleep && !half_r && tick_cnt_r == 8'h00)
                fetch_r[fetch_idx_d_r] <= mem_rdata;
        end
    end

    // pin drive: selected common active, segment level xor phase gives zero dc
    wire logic phase = wft_r ? frame_par_r : half_r;
    genvar g;
    generate
        for (g = 0; g < NUM_COMS; g++)
        begin : g_com
            always_ff @(posedge sys_clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    com_drive[g] <= 1'b0;
                    com_phase[g] <= 1'b0;
                end
                else if (asleep && sleep_shutdown_enable)
                begin
                    com_drive[g] <= 1'b0;
                    com_phase[g] <= 1'b0;
                end
                else if (!freeze_sleep)
                begin
                    com_drive[g] <= display_active_flag_r && (slot_r == g) &&
                                    (2'(g) <= multiplex_select);
                    com_phase[g] <= phase;
                end
            end
        end
        for (g = 0; g < NUM_SEGS; g++)
        begin : g_seg
            always_ff @(posedge sys_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    seg_drive[g] <= 1'b0;
                else if (asleep && sleep_shutdown_enable)
                    seg_drive[g] <= 1'b0;
                else if (!freeze_sleep)
                    seg_drive[g] <= display_active_flag_r &&
                                    (fetch_r[g / DATA_W][g % DATA_W] ^ phase);
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pins_lcd_mode <= 1'b0;
        else
            pins_lcd_mode <= display_active_flag_r;
    end

    // control registers; write error set wins over software clear
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_r <= '0;
            wft_r  <= 1'b0;
            ie_r   <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == ADDR_CTRL)
                ctrl_r <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_CFG)
            begin
                wft_r <= reg_wdata[CFG_WFT_BIT];
                ie_r  <= reg_wdata[CFG_IE_BIT];
            end
            if (reg_wr && is_pix && !write_ok)
                ctrl_r[CTRL_WRITE_ERROR_FLAG_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            active_d_r <= 1'b0;
        else
            active_d_r <= display_active_flag_r;
    end

    wire logic fall_ev  = active_d_r && !display_active_flag_r;
    wire logic frame_ev = fetch_done && frame_irq_on && frame_par_r;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            display_irq_flag_r <= 1'b0;
        else if (fall_ev || frame_ev)
            display_irq_flag_r <= 1'b1;
        else if (reg_wr && reg_addr == ADDR_STAT && !reg_wdata[STAT_IF_BIT])
            display_irq_flag_r <= 1'b0;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            display_irq <= 1'b0;
            wake_req    <= 1'b0;
        end
        else
        begin
            display_irq <= display_irq_flag_r && ie_r;
            wake_req    <= asleep && slow_osc && !sleep_shutdown_enable &&
                           frame_irq_on && ie_r && frame_start;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_pend_r <= 1'b0;
            rd_hold_r <= '0;
        end
        else
        begin
            rd_pend_r <= reg_rd && is_pix;
            case (reg_addr)
                ADDR_CTRL: rd_hold_r <= ctrl_r;
                ADDR_CFG:  rd_hold_r <= {wft_r, 6'h00, ie_r};
                ADDR_STAT: rd_hold_r <= {5'h00, display_active_flag_r, 1'b0,
                                         display_irq_flag_r};
                default:   rd_hold_r <= '0;
            endcase
            if (!reg_rd)
                rd_hold_r <= '0;
        end
    end
    always_comb
    begin
        reg_rdata = rd_pend_r ? mem_rdata : rd_hold_r;
    end
endmodule

/* File: tb/lcd_frame_seq_monitor.sv */
// port checker for the frame sequencer
// assumes it is bound to lcd_frame_seq in one clock domain
module lcd_frame_seq_monitor
    import lcd_seq_pkg::*;
(
    input wire logic                sys_clk,
    input wire logic                sys_rst,
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic [DATA_W-1:0]   reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [DATA_W-1:0]   reg_rdata,
    input wire logic                sleep_req,
    input wire logic                sec_osc_clk,
    input wire logic                lf_osc_clk,
    input wire logic                display_irq,
    input wire logic                wake_req,
    input wire logic [NUM_COMS-1:0] com_drive,
    input wire logic [NUM_COMS-1:0] com_phase,
    input wire logic [NUM_SEGS-1:0] seg_drive,
    input wire logic                pins_lcd_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ctrl_r;
    logic [7:0] cfg_r;
    logic [3:0] quiet_r;
    logic [3:0] mask;
    assign mask = 4'hF >> (2'h3 - ctrl_r[1:0]);
    // shadow of control and config, cycles since last change
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_r  <= 8'h00;
            cfg_r   <= 8'h00;
            quiet_r <= 4'h0;
        end
        else
        begin
            quiet_r <= (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
            if (reg_wr && reg_addr == ADDR_CTRL)
            begin
                ctrl_r  <= reg_wdata;
                quiet_r <= 4'h0;
            end
            if (reg_wr && reg_addr == ADDR_CFG)
            begin
                cfg_r   <= reg_wdata;
                quiet_r <= 4'h0;
            end
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence grounded;
        com_drive == 4'h0 && seg_drive == '0;
    endsequence
    sequence act_fall;
        $fell(pins_lcd_mode) && cfg_r[CFG_IE_BIT];
    endsequence
    sequence en_write;
        reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_EN_BIT] && !sleep_req;
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    coms_onehot_a: assert property ($onehot0(com_drive))
        else $error("more than one common slot active");
    mux_width_a: assert property (quiet_r == 4'hF |-> (com_drive & ~mask) == 4'h0)
        else $error("common outside multiplex select driven");
    irq_needs_en_a: assert property (!cfg_r[CFG_IE_BIT] && quiet_r == 4'hF |-> !display_irq)
        else $error("interrupt request with enable clear");
    wake_cond_a: assert property (wake_req |-> cfg_r[7] && cfg_r[0] && ctrl_r[1:0] != 2'h0
        ##1 !wake_req)
        else $error("wake pulse without frame interrupts");
    shutdown_irq_a: assert property (act_fall |-> ##[0:3] display_irq)
        else $error("no interrupt after active flag fell");
    enable_rise_a: assert property (en_write |-> ##[1:5] pins_lcd_mode)
        else $error("active flag not set after enable");
    active_hold_a: assert property (pins_lcd_mode && ctrl_r[7] && !sleep_req
        && !$past(sleep_req, 4) |=> pins_lcd_mode)
        else $error("active flag dropped while enabled");
    sleep_ground_a: assert property ($rose(sleep_req) && ctrl_r[6]
        |-> ##[1:5] grounded ##1 grounded [*3])
        else $error("lines not grounded on shutdown sleep");
endmodule
bind lcd_frame_seq lcd_frame_seq_monitor mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_req(sleep_req), .sec_osc_clk(sec_osc_clk),
    .lf_osc_clk(lf_osc_clk), .display_irq(display_irq), .wake_req(wake_req),
    .com_drive(com_drive), .com_phase(com_phase), .seg_drive(seg_drive),
    .pins_lcd_mode(pins_lcd_mode));

/* File: tb/lcd_glass_model.sv */
// display glass model: dc charge seen by each common electrode
// assumes com_phase gives the drive polarity of the driven common
module lcd_glass_model
    import lcd_seq_pkg::*;
(
    input wire logic                sys_clk,
    input wire logic                clr,
    input wire logic [NUM_COMS-1:0] com_drive,
    input wire logic [NUM_COMS-1:0] com_phase,
    output int                      peak
);
    timeunit 1ns;
    timeprecision 100ps;
    int dc [NUM_COMS];
    always @(posedge sys_clk)
    begin
        for (int c = 0; c < NUM_COMS; c++)
        begin
            if (clr)
                dc[c] = 0;
            else if (com_drive[c])
                dc[c] += com_phase[c] ? 1 : -1;
            if (clr)
                peak = 0;
            else if (dc[c] > peak || -dc[c] > peak)
                peak = (dc[c] > 0) ? dc[c] : -dc[c];
        end
    end
endmodule

/* File: tb/test_lcd_frame_seq.sv */
// self-checking bench for the frame sequencer
// assumes the checker is bound by its own file
module test_lcd_frame_seq;
    import lcd_seq_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d;} row_t;
    logic                sys_clk, sys_rst, reg_wr, reg_rd, sleep_req, glass_clr, irq_seen;
    logic                sec_osc_clk, lf_osc_clk, display_irq, wake_req, pins_lcd_mode;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata, reg_rdata, rv;
    logic [NUM_COMS-1:0] com_drive, com_phase, seen_c, snap_c;
    logic [NUM_SEGS-1:0] seg_drive, snap_s;
    logic [2:0]          osc_cnt;
    int                  mismatches, num_checks, cycles, dc_peak, i;
    row_t rows [0:9] = '{'{1'b1, 4'h0, 8'hA5}, '{1'b1, 4'hB, 8'h3C}, '{1'b0, 4'h0, 8'hA5},
        '{1'b0, 4'hB, 8'h3C}, '{1'b0, 4'hF, 8'h00}, '{1'b1, 4'hD, 8'h80},
        '{1'b0, 4'hD, 8'h80}, '{1'b0, 4'hE, 8'h00}, '{1'b1, 4'hC, 8'h03},
        '{1'b0, 4'hC, 8'h03}};
    assign sec_osc_clk = osc_cnt[1];
    assign lf_osc_clk = osc_cnt[2];
    lcd_frame_seq dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_req(sleep_req), .sec_osc_clk(sec_osc_clk), .lf_osc_clk(lf_osc_clk),
        .display_irq(display_irq), .wake_req(wake_req), .com_drive(com_drive),
        .com_phase(com_phase), .seg_drive(seg_drive), .pins_lcd_mode(pins_lcd_mode));
    lcd_glass_model glass (.sys_clk(sys_clk), .clr(glass_clr), .com_drive(com_drive),
        .com_phase(com_phase), .peak(dc_peak));
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        osc_cnt <= osc_cnt + 3'h1;
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, sleep_req, reg_addr, reg_wdata, osc_cnt} = '0;
        {mismatches, num_checks, cycles} = '0;
        glass_clr = 1'b1;
        cyc(5);
        sys_rst <= 1'b0;
        cyc(1);
        chk({com_drive, seg_drive, display_irq, wake_req, pins_lcd_mode}, 32'h0);
        for (i = 0; i < 10; i++)
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            else
            begin
                rd(rows[i].a, rv);
                chk(rv, rows[i].d);
            end
        // type a, four commons, no frame interrupt
        wr(ADDR_CFG, 8'h01);
        wr(ADDR_CTRL, 8'h87);
        glass_clr <= 1'b0;
        {seen_c, irq_seen} = '0;
        for (i = 0; i < 1200; i++)
        begin
            @(posedge sys_clk);
            seen_c |= com_drive;
            irq_seen |= display_irq;
        end
        chk({seen_c, irq_seen}, {4'hF, 1'b0});
        chk(dc_peak <= 100, 1);
        while (com_drive != 4'h1) @(posedge sys_clk);
        cyc(40);
        chk(seg_drive ^ {NUM_SEGS{com_phase[0]}}, 24'h0000A5);
        while (com_drive != 4'h8) @(posedge sys_clk);
        cyc(40);
        chk(seg_drive ^ {NUM_SEGS{com_phase[3]}}, 24'h3C0000);
        // type b: frame interrupt, refused and accepted writes
        glass_clr <= 1'b1;
        wr(ADDR_CFG, 8'h81);
        glass_clr <= 1'b0;
        for (i = 0; i < 3000 && !display_irq; i++) @(posedge sys_clk);
        chk(i < 3000, 1);
        wr(ADDR_STAT, 8'h00);
        cyc(2);
        chk(display_irq, 0);
        cyc(200);
        wr(4'h0, 8'h11);
        rd(4'h0, rv);
        chk(rv, 8'hA5);
        rd(ADDR_CTRL, rv);
        chk(rv[CTRL_WRITE_ERROR_FLAG_BIT], 1);
        wr(ADDR_CTRL, 8'h87);
        for (i = 0; i < 3000 && !display_irq; i++) @(posedge sys_clk);
        wr(4'h0, 8'h22);
        rd(4'h0, rv);
        chk(rv, 8'h22);
        rd(ADDR_CTRL, rv);
        chk(rv[CTRL_WRITE_ERROR_FLAG_BIT], 0);
        chk(dc_peak <= 200, 1);
        // sleep while refreshing: writes blocked, wake at frame boundary
        wr(ADDR_STAT, 8'h00);
        sleep_req <= 1'b1;
        cyc(4);
        wr(4'h0, 8'h33);
        rd(4'h0, rv);
        chk(rv, 8'h22);
        for (i = 0; i < 3000 && !wake_req; i++) @(posedge sys_clk);
        chk({i < 3000, pins_lcd_mode}, 2'h3);
        sleep_req <= 1'b0;
        cyc(4);
        // disable: frame finishes, then interrupt
        wr(ADDR_STAT, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        cyc(8);
        chk(pins_lcd_mode, 1);
        for (i = 0; i < 1200 && pins_lcd_mode; i++) @(posedge sys_clk);
        chk(i < 1200, 1);
        sleep_req <= 1'b1;
        cyc(4);
        chk({display_irq, com_drive, pins_lcd_mode}, 6'h20);
        rd(ADDR_STAT, rv);
        chk(rv, 8'h01);
        wr(ADDR_CFG, 8'h00);
        cyc(2);
        chk(display_irq, 0);
        // quarter-rate clock, then divide-by-256: pattern frozen in sleep
        wr(ADDR_CFG, 8'h01);
        for (i = 0; i < 2; i++)
        begin
            sleep_req <= 1'b0;
            cyc(4);
            wr(ADDR_CTRL, i ? 8'h8F : 8'h83);
            cyc(20);
            sleep_req <= 1'b1;
            cyc(8);
            snap_c = com_drive;
            snap_s = seg_drive;
            cyc(600);
            chk({com_drive, seg_drive}, {snap_c, snap_s});
            chk(snap_c != 4'h0, 1);
        end
        // shutdown sleep grounds every line
        sleep_req <= 1'b0;
        cyc(4);
        wr(ADDR_CTRL, 8'hC7);
        cyc(20);
        sleep_req <= 1'b1;
        cyc(8);
        chk({com_drive, seg_drive}, 32'h0);
        wrap_up();
    end
endmodule
